// ---- src/idaa_mem.sv ----
// Flip-flop storage for the data array records
`timescale 1ns/1ps
module idaa_mem
  import idaa_pkg::*;
#(
  parameter int unsigned DEPTH  = IDAA_RECORDS,
  parameter int unsigned ADDR_W = IDAA_ADDR_W,
  parameter int unsigned DATA_W = IDAA_DATA_W
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_we,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  output logic      [DATA_W-1:0] o_rdata
);
  // Contents are not cleared by reset, like a backed-up table
  logic [DATA_W-1:0] mem_q [DEPTH];

  // Write port
  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem_q[i_addr] <= i_wdata;
    end
  end

  // Read port, caller keeps address in range
  assign o_rdata = mem_q[i_addr];
endmodule

// ---- src/idaa_pkg.sv ----
// Shared constants for the indexed data array access block
package idaa_pkg;
  // Array geometry
  localparam int unsigned IDAA_DATA_W   = 32;
  localparam int unsigned IDAA_HALF_W   = 16;
  localparam int unsigned IDAA_RECORDS  = 800;
  localparam int unsigned IDAA_ADDR_W   = 10;
  // Keypad parameter selects
  localparam logic [1:0] IDAA_KP_CAP    = 2'h0;
  localparam logic [1:0] IDAA_KP_INDEX  = 2'h1;
  localparam logic [1:0] IDAA_KP_WIN1   = 2'h2;
  localparam logic [1:0] IDAA_KP_WIN2   = 2'h3;
  // Communication word offsets: each parameter is a low then a high word
  localparam logic [2:0] IDAA_CM_CAP_LO = 3'h0;
  localparam logic [2:0] IDAA_CM_CAP_HI = 3'h1;
  localparam logic [2:0] IDAA_CM_IDX_LO = 3'h2;
  localparam logic [2:0] IDAA_CM_IDX_HI = 3'h3;
  localparam logic [2:0] IDAA_CM_W1_LO  = 3'h4;
  localparam logic [2:0] IDAA_CM_W1_HI  = 3'h5;
  localparam logic [2:0] IDAA_CM_W2_LO  = 3'h6;
  localparam logic [2:0] IDAA_CM_W2_HI  = 3'h7;
  // Reset values, plus the zero and one constants
  localparam logic [31:0] IDAA_INDEX_RST = 32'h0000_0000;
  localparam logic [15:0] IDAA_HALF_RST  = 16'h0000;
  localparam logic [31:0] IDAA_ZERO32    = 32'h0000_0000;
  localparam logic [31:0] IDAA_ONE32     = 32'h0000_0001;
endpackage

// ---- src/idaa_top.sv ----
// Indexed data array access: one index, two windows, keypad and comm port
//
// Overview of operation
// - Array contents reach outside only via index and two window parameters.
// - Read-only capacity parameter reports N, the count of 32-bit entries.
// - One shared index selects the entry for either window.
// - Keypad read of window one returns entry, index unchanged.
// - Keypad write of window one stores entry, then index plus one.
// - Comm read of window one returns entry, then index plus one.
// - Keypad read of window two returns entry, then index plus one.
// - Keypad write to window two is rejected.
// - Comm read or write of either window accesses entry, then index plus one.
// - Six-word write loads index, window one, window two, low then high.
// - While window two shown, set key shows next entry, mode key exits.
// - Valid index values run from zero to the last of 800 records.
`timescale 1ns/1ps
module idaa_top
  import idaa_pkg::*;
#(
  parameter int unsigned RECORDS = IDAA_RECORDS
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // Keypad parameter access, same clock domain
  input  wire logic        i_kp_req,
  input  wire logic        i_kp_wr,
  input  wire logic [1:0]  i_kp_sel,
  input  wire logic [31:0] i_kp_wdata,
  input  wire logic        i_kp_set_key,
  input  wire logic        i_kp_mode_key,
  output logic             o_kp_ack,
  output logic             o_kp_rej,
  output logic [31:0]      o_kp_rdata,
  output logic             o_kp_win2_shown,
  // Communication word access, same clock domain
  input  wire logic        i_cm_req,
  input  wire logic        i_cm_wr,
  input  wire logic [2:0]  i_cm_word,
  input  wire logic [15:0] i_cm_wdata,
  output logic             o_cm_ack,
  output logic [15:0]      o_cm_rdata
);
  localparam logic [31:0] CAPACITY = RECORDS[31:0];

  typedef struct packed {
    logic [31:0] index;
    logic [15:0] wr_lo;
    logic [15:0] rd_hi;
    logic [31:0] kp_rdata;
    logic        kp_ack;
    logic        kp_rej;
    logic        shown;
    logic [15:0] cm_rdata;
    logic        cm_ack;
  } idaa_state_type;

  idaa_state_type st_q;
  idaa_state_type st_d;

  logic        mem_we;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;

  // Index usable only below capacity
  function automatic logic idaa_in_range(input logic [31:0] idx);
    return idx < CAPACITY;
  endfunction

  // Next index after a window access that steps
  function automatic logic [31:0] idaa_step(input logic [31:0] idx);
    return idaa_in_range(idx) ? idx + IDAA_ONE32 : idx;
  endfunction

  // Entry read, zero when the index is out of range
  function automatic logic [31:0] idaa_entry(input logic [31:0] idx,
                                             input logic [31:0] raw);
    return idaa_in_range(idx) ? raw : IDAA_ZERO32;
  endfunction

  logic        kp_take;
  logic        kp_set_rd;
  logic        win_ok;
  logic [31:0] cm_entry;

  // Comm has priority; keypad holds its request until acked
  assign kp_set_rd = i_kp_set_key && st_q.shown && !i_kp_req;
  assign kp_take   = (i_kp_req || kp_set_rd) && !i_cm_req;
  assign win_ok    = idaa_in_range(st_q.index);

  // Zero outside the array so a bad index never leaks entry 0
  assign cm_entry  = idaa_entry(st_q.index, mem_rdata);

  // Access decode and index stepping
  always_comb begin
    st_d         = st_q;
    st_d.kp_ack  = 1'b0;
    st_d.kp_rej  = 1'b0;
    st_d.cm_ack  = 1'b0;
    mem_we       = 1'b0;
    mem_wdata    = IDAA_ZERO32;
    if (i_kp_mode_key) begin
      st_d.shown = 1'b0;
    end
    // Comm wins a shared cycle; a set key pressed then is dropped
    if (i_cm_req) begin
      st_d.cm_ack = 1'b1;
      unique case (i_cm_word)
        IDAA_CM_CAP_LO: st_d.cm_rdata = CAPACITY[15:0];
        IDAA_CM_CAP_HI: st_d.cm_rdata = CAPACITY[31:16];
        IDAA_CM_IDX_LO: begin
          st_d.cm_rdata = st_q.index[15:0];
          if (i_cm_wr) begin
            st_d.wr_lo = i_cm_wdata;
          end
        end
        IDAA_CM_IDX_HI: begin
          st_d.cm_rdata = st_q.index[31:16];
          if (i_cm_wr) begin
            st_d.index = {i_cm_wdata, st_q.wr_lo};
          end
        end
        IDAA_CM_W1_LO, IDAA_CM_W2_LO: begin
          if (i_cm_wr) begin
            st_d.wr_lo = i_cm_wdata;
          end else begin
            // Whole entry fetched on the low word, high word held
            // so a later high read cannot tear across two entries
            st_d.cm_rdata = cm_entry[15:0];
            st_d.rd_hi    = cm_entry[31:16];
            st_d.index = idaa_step(st_q.index);
          end
        end
        IDAA_CM_W1_HI, IDAA_CM_W2_HI: begin
          st_d.cm_rdata = st_q.rd_hi;
          if (i_cm_wr) begin
            // Commit on the high word so both halves land together
            mem_we     = win_ok;
            mem_wdata  = {i_cm_wdata, st_q.wr_lo};
            st_d.index = idaa_step(st_q.index);
          end
        end
        default: st_d.cm_rdata = IDAA_HALF_RST;
      endcase
    end else if (kp_take) begin
      st_d.kp_ack = 1'b1;
      if (kp_set_rd) begin
        st_d.kp_rdata = idaa_entry(st_q.index, mem_rdata);
        st_d.index    = idaa_step(st_q.index);
      end else begin
        unique case (i_kp_sel)
          IDAA_KP_CAP: begin
            st_d.kp_rdata = CAPACITY;
            st_d.kp_rej   = i_kp_wr;
          end
          IDAA_KP_INDEX: begin
            st_d.kp_rdata = st_q.index;
            if (i_kp_wr) begin
              st_d.index = i_kp_wdata;
            end
          end
          IDAA_KP_WIN1: begin
            st_d.kp_rdata = idaa_entry(st_q.index, mem_rdata);
            if (i_kp_wr) begin
              mem_we     = win_ok;
              mem_wdata  = i_kp_wdata;
              st_d.index = idaa_step(st_q.index);
            end
          end
          IDAA_KP_WIN2: begin
            if (i_kp_wr) begin
              st_d.kp_rej = 1'b1;
            end else begin
              st_d.kp_rdata = idaa_entry(st_q.index, mem_rdata);
              st_d.index    = idaa_step(st_q.index);
              st_d.shown    = 1'b1;
            end
          end
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_q.index    <= IDAA_INDEX_RST;
      st_q.wr_lo    <= IDAA_HALF_RST;
      st_q.rd_hi    <= IDAA_HALF_RST;
      st_q.kp_rdata <= IDAA_ZERO32;
      st_q.kp_ack   <= 1'b0;
      st_q.kp_rej   <= 1'b0;
      st_q.shown    <= 1'b0;
      st_q.cm_rdata <= IDAA_HALF_RST;
      st_q.cm_ack   <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Only path into the array is the window decode above
  idaa_mem #(
    .DEPTH  (RECORDS),
    .ADDR_W (IDAA_ADDR_W),
    .DATA_W (IDAA_DATA_W)
  ) u_mem (
    .i_sys_clk (i_sys_clk),
    .i_we      (mem_we),
    .i_addr    (win_ok ? st_q.index[IDAA_ADDR_W-1:0] : '0),
    .i_wdata   (mem_wdata),
    .o_rdata   (mem_rdata)
  );

  assign o_kp_ack        = st_q.kp_ack;
  assign o_kp_rej        = st_q.kp_rej;
  assign o_kp_rdata      = st_q.kp_rdata;
  assign o_kp_win2_shown = st_q.shown;
  assign o_cm_ack        = st_q.cm_ack;
  assign o_cm_rdata      = st_q.cm_rdata;
endmodule

// ---- tb/idaa_bench.sv ----
// Self-checking bench for the indexed array access block
`timescale 1ns/1ps
module idaa_bench;
  import idaa_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        kq = 1'b0;
  logic        kw = 1'b0;
  logic [1:0]  ks = 2'h0;
  logic [31:0] kd = 32'h0;
  logic        set_k = 1'b0;
  logic        mode_k = 1'b0;
  logic        ka, kj, shown, cq, cw, ca;
  logic [31:0] krd, kr;
  logic [2:0]  cword;
  logic [15:0] cwd, crd;
  int          err_total = 0;
  int          n_tests = 0;
  // Slow 10 MHz clock keeps all counts short
  always #50 clk = ~clk;
  idaa_top u_idaa_top (.i_sys_clk(clk), .i_rst(rst), .i_kp_req(kq),
    .i_kp_wr(kw), .i_kp_sel(ks), .i_kp_wdata(kd), .i_kp_set_key(set_k),
    .i_kp_mode_key(mode_k), .o_kp_ack(ka), .o_kp_rej(kj),
    .o_kp_rdata(krd), .o_kp_win2_shown(shown), .i_cm_req(cq),
    .i_cm_wr(cw), .i_cm_word(cword), .i_cm_wdata(cwd), .o_cm_ack(ca),
    .o_cm_rdata(crd));
  idaa_host u_idaa_host (.i_sys_clk(clk), .i_ack(ca), .i_rdata(crd),
    .o_req(cq), .o_wr(cw), .o_word(cword), .o_wdata(cwd));
  task automatic check_val(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Keypad request for one cycle while the comm port is idle
  task automatic kp(input logic wr, input logic [1:0] s, input logic [31:0] d);
    @(negedge clk);
    kq = 1'b1;
    kw = wr;
    ks = s;
    kd = d;
    @(negedge clk);
    kq = 1'b0;
    kd = ~d;
    kr = ka ? krd : 32'hBAD0BAD0;
  endtask
  task automatic key(input logic set);
    @(negedge clk);
    set_k = set;
    mode_k = !set;
    @(negedge clk);
    set_k = 1'b0;
    mode_k = 1'b0;
    kr = ka ? krd : 32'hBAD0BAD0;
  endtask
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog: the sequence needs about 90 cycles
  initial begin
    #200000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    kp(1'b0, IDAA_KP_CAP, 32'h0); check_val(kr, IDAA_RECORDS);
    kp(1'b1, IDAA_KP_CAP, 32'h5); check_val(kj, 32'h1);
    kp(1'b1, IDAA_KP_INDEX, 32'hB);
    kp(1'b1, IDAA_KP_WIN1, 32'h64);
    kp(1'b1, IDAA_KP_WIN1, 32'hC8);
    kp(1'b0, IDAA_KP_INDEX, 32'h0); check_val(kr, 32'hD);
    kp(1'b1, IDAA_KP_INDEX, 32'hB);
    kp(1'b0, IDAA_KP_WIN1, 32'h0); check_val(kr, 32'h64);
    kp(1'b0, IDAA_KP_WIN2, 32'h0); check_val(kr, 32'h64);
    key(1'b1); check_val(kr, 32'hC8);
    key(1'b0); check_val(shown, 32'h0);
    kp(1'b1, IDAA_KP_WIN2, 32'h5); check_val(kj, 32'h1);
    kp(1'b0, IDAA_KP_INDEX, 32'h0); check_val(kr, 32'hD);
    u_idaa_host.frame(32'h14, 32'h12C, 32'h30190);
    u_idaa_host.word(1'b0, IDAA_CM_IDX_LO, 16'h0);
    check_val(u_idaa_host.rd_q, 32'h16);
    u_idaa_host.word(1'b1, IDAA_CM_IDX_LO, 16'h14);
    u_idaa_host.word(1'b1, IDAA_CM_IDX_HI, 16'h0);
    u_idaa_host.word(1'b0, IDAA_CM_W1_LO, 16'h0);
    check_val(u_idaa_host.rd_q, 32'h12C);
    u_idaa_host.word(1'b0, IDAA_CM_W2_LO, 16'h0);
    check_val(u_idaa_host.rd_q, 32'h190);
    u_idaa_host.word(1'b0, IDAA_CM_W2_HI, 16'h0);
    check_val(u_idaa_host.rd_q, 32'h3);
    u_idaa_host.word(1'b1, IDAA_CM_CAP_LO, 16'h5);
    u_idaa_host.word(1'b0, IDAA_CM_CAP_LO, 16'h0);
    check_val(u_idaa_host.rd_q, IDAA_RECORDS & 32'hFFFF);
    u_idaa_host.word(1'b0, IDAA_CM_CAP_HI, 16'h0);
    check_val(u_idaa_host.rd_q, IDAA_RECORDS >> 16);
    kp(1'b1, IDAA_KP_INDEX, 32'h31F);
    kp(1'b1, IDAA_KP_WIN1, 32'h7);
    kp(1'b0, IDAA_KP_INDEX, 32'h0); check_val(kr, IDAA_RECORDS);
    kp(1'b1, IDAA_KP_WIN1, 32'h9);
    kp(1'b0, IDAA_KP_INDEX, 32'h0); check_val(kr, IDAA_RECORDS);
    u_idaa_host.word(1'b0, IDAA_CM_W1_LO, 16'h0);
    check_val(u_idaa_host.rd_q, 32'h0);
    kp(1'b1, IDAA_KP_INDEX, 32'h31F);
    kp(1'b0, IDAA_KP_WIN1, 32'h0); check_val(kr, 32'h7);
    kp(1'b0, IDAA_KP_WIN2, 32'h0); check_val(kr, 32'h7);
    // Mid-run reset: index and display state clear, array contents kept
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check_val(shown, 32'h0);
    kp(1'b0, IDAA_KP_INDEX, 32'h0); check_val(kr, 32'h0);
    kp(1'b1, IDAA_KP_INDEX, 32'h31F);
    kp(1'b0, IDAA_KP_WIN1, 32'h0); check_val(kr, 32'h7);
    tally_and_finish;
  end
endmodule
bind idaa_top idaa_checker #(.RECORDS(RECORDS)) u_idaa_checker (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_kp_req(i_kp_req),
  .i_kp_wr(i_kp_wr), .i_kp_sel(i_kp_sel), .i_kp_set_key(i_kp_set_key),
  .i_kp_mode_key(i_kp_mode_key), .o_kp_ack(o_kp_ack),
  .o_kp_rej(o_kp_rej), .o_kp_rdata(o_kp_rdata),
  .o_kp_win2_shown(o_kp_win2_shown), .i_cm_req(i_cm_req),
  .o_cm_ack(o_cm_ack));

// ---- tb/idaa_checker.sv ----
// Port assertions for the indexed array access block
`timescale 1ns/1ps
module idaa_checker
  import idaa_pkg::*;
#(
  parameter int unsigned RECORDS = IDAA_RECORDS
) (
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        i_kp_req,
  input wire logic        i_kp_wr,
  input wire logic [1:0]  i_kp_sel,
  input wire logic        i_kp_set_key,
  input wire logic        i_kp_mode_key,
  input wire logic        o_kp_ack,
  input wire logic        o_kp_rej,
  input wire logic [31:0] o_kp_rdata,
  input wire logic        o_kp_win2_shown,
  input wire logic        i_cm_req,
  input wire logic        o_cm_ack
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Keypad access taken only when the comm port is idle
  sequence kp_take;
    i_kp_req && !i_cm_req;
  endsequence
  sequence kp_op(logic w, logic [1:0] s);
    kp_take ##0 (i_kp_wr == w && i_kp_sel == s);
  endsequence
  cm_ack_a: assert property (i_cm_req |=> o_cm_ack)
    else $error("comm ack missing");
  cm_quiet_a: assert property (!i_cm_req |=> !o_cm_ack)
    else $error("comm ack without request");
  kp_ack_a: assert property (kp_take |=> o_kp_ack)
    else $error("keypad ack missing");
  rej_ack_a: assert property (o_kp_rej |-> o_kp_ack)
    else $error("reject without ack");
  win2_rej_a: assert property (kp_op(1'b1, IDAA_KP_WIN2) |=> o_kp_rej)
    else $error("window two write accepted");
  read_ok_a: assert property (kp_take ##0 !i_kp_wr |=> !o_kp_rej)
    else $error("keypad read refused");
  win2_shown_a: assert property (kp_op(1'b0, IDAA_KP_WIN2) |=> o_kp_win2_shown)
    else $error("window two not shown");
  mode_exit_a: assert property (i_kp_mode_key && !i_kp_req && !i_kp_set_key
    |=> !o_kp_win2_shown)
    else $error("mode key did not exit");
  cap_value_a: assert property (kp_op(1'b0, IDAA_KP_CAP)
    |=> o_kp_rdata == RECORDS)
    else $error("capacity value wrong");
endmodule

// ---- tb/idaa_host.sv ----
// Host controller model driving comm word accesses
`timescale 1ns/1ps
module idaa_host
  import idaa_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_ack,
  input  wire logic [15:0] i_rdata,
  output logic             o_req,
  output logic             o_wr,
  output logic [2:0]       o_word,
  output logic [15:0]      o_wdata
);
  logic [15:0] rd_q;
  initial begin
    o_req = 1'b0;
    o_wr = 1'b0;
    o_word = 3'h0;
    o_wdata = 16'h0000;
  end
  // One word a request; data inverted once released so stale values never match
  task automatic word(input logic wr, input logic [2:0] w, input logic [15:0] d);
    @(negedge i_sys_clk);
    o_req = 1'b1;
    o_wr = wr;
    o_word = w;
    o_wdata = d;
    @(negedge i_sys_clk);
    o_req = 1'b0;
    o_wdata = ~d;
    rd_q = i_ack ? i_rdata : 16'hDEAD;
  endtask
  // Six-word frame: index first, then both windows, low word before high
  task automatic frame(input logic [31:0] idx, a, b);
    word(1'b1, IDAA_CM_IDX_LO, idx[15:0]);
    word(1'b1, IDAA_CM_IDX_HI, idx[31:16]);
    word(1'b1, IDAA_CM_W1_LO, a[15:0]);
    word(1'b1, IDAA_CM_W1_HI, a[31:16]);
    word(1'b1, IDAA_CM_W2_LO, b[15:0]);
    word(1'b1, IDAA_CM_W2_HI, b[31:16]);
  endtask
endmodule
